// >>> rtl/tts_pkg.sv
// Constants, field layout and carrier types of the touch timing scheduler.
// Assumes a 250 MHz system clock and an 8-bit register port.
//
// Functional notes
// - Hold-limit code 0..15 selects 560 ms to 11200 ms; reset code is 10.
// - Touch held past the hold limit requests recalibration of that input.
// - Repeat interrupts are spaced (code+1)*35 ms; reset code is 4.
// - Hold-detect threshold (code+1)*35 ms, reset 7, repeat inputs only.
// - Repeat input touched longer than threshold becomes a press-and-hold.
// - Repeat input touched no longer than threshold stays a plain touch.
// - Samples per measurement are two to the sample-count code, reset 8.
// - All samples of one channel come back to back, channels in turn.
// - Channel result is updated only after averaging all its samples.
// - Sample period code selects 320 us, 640 us, 1.28 ms or 2.56 ms.
// - Cycle code selects a 35, 70, 105 or 140 ms sensing cycle; reset 1.
// - Each sensing cycle begins by sampling all enabled channels.
// - After sampling the block idles in low power until cycle end.
// - Overlong sampling stretches the cycle; sample count has priority.
// - Hold-limit recalibration only while the global enable bit is one.
// - Press-and-hold interrupts at touch, then at each repeat interval.
// - Repeat-disabled input interrupts only on touch and optional release.
package tts_pkg;

  // Timebase
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned US_PER_MS     = 1000;

  // Timing figures
  localparam int unsigned REPEAT_STEP_MS = 35;
  localparam int unsigned PRESS_STEP_MS  = 35;
  localparam int unsigned CYCLE_STEP_MS  = 35;
  localparam int unsigned SAMPLE_BASE_US = 320;

  // Register offsets
  localparam logic [7:0] OFF_GLOBAL_CONFIG  = 8'h20;
  localparam logic [7:0] OFF_CHANNEL_ENABLE = 8'h21;
  localparam logic [7:0] OFF_TOUCH_TIMING   = 8'h22;
  localparam logic [7:0] OFF_HOLD_DETECT    = 8'h23;
  localparam logic [7:0] OFF_AVG_SAMPLING   = 8'h24;
  localparam logic [7:0] OFF_REPEAT_ENABLE  = 8'h28;
  localparam logic [7:0] OFF_EVENT_STATUS   = 8'h30;
  localparam logic [7:0] OFF_EVENT_MASK     = 8'h31;
  localparam logic [7:0] OFF_HOLD_STATE     = 8'h32;
  localparam logic [7:0] OFF_SEQ_STATUS     = 8'h33;

  // Reset values
  localparam logic [7:0] RST_GLOBAL_CONFIG  = 8'h00;
  localparam logic [7:0] RST_CHANNEL_ENABLE = 8'hff;
  localparam logic [7:0] RST_TOUCH_TIMING   = 8'ha4;
  localparam logic [7:0] RST_HOLD_DETECT    = 8'h07;
  localparam logic [7:0] RST_AVG_SAMPLING   = 8'h39;
  localparam logic [7:0] RST_REPEAT_ENABLE  = 8'hff;
  localparam logic [7:0] RST_EVENT_MASK     = 8'hff;

  // Field positions
  localparam int unsigned GC_REL_INT_DIS_BIT = 0;
  localparam int unsigned GC_RECAL_EN_BIT    = 3;
  localparam int unsigned TT_HOLD_LSB        = 4;
  localparam int unsigned TT_REPEAT_LSB      = 0;
  localparam int unsigned HD_PRESS_LSB       = 0;
  localparam int unsigned AS_COUNT_LSB       = 4;
  localparam int unsigned AS_PERIOD_LSB      = 2;
  localparam int unsigned AS_CYCLE_LSB       = 0;
  localparam int unsigned SS_LOW_POWER_BIT   = 4;
  localparam int unsigned SS_SAMPLING_BIT    = 5;

  // Hold-limit decode in ms
  function automatic logic [13:0] hold_limit_ms(input logic [3:0] code);
    logic [13:0] ms;
    ms = 14'd0;
    unique case (code)
      4'h0: ms = 14'd560;
      4'h1: ms = 14'd840;
      4'h2: ms = 14'd1120;
      4'h3: ms = 14'd1400;
      4'h4: ms = 14'd1680;
      4'h5: ms = 14'd2240;
      4'h6: ms = 14'd2800;
      4'h7: ms = 14'd3360;
      4'h8: ms = 14'd3920;
      4'h9: ms = 14'd4480;
      4'ha: ms = 14'd5600;
      4'hb: ms = 14'd6720;
      4'hc: ms = 14'd7840;
      4'hd: ms = 14'd8906;
      4'he: ms = 14'd10080;
      4'hf: ms = 14'd11200;
    endcase
    return ms;
  endfunction

  typedef enum logic [1:0] {
    TTS_SLEEP  = 2'b00,
    TTS_SEEK   = 2'b01,
    TTS_SAMPLE = 2'b11
  } tts_seq_state_t;

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } tts_sample_req_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  channel;
    logic [15:0] value;
  } tts_result_t;

endpackage

// >>> rtl/tts_scheduler.sv
// Touch timing scheduler: sensing-cycle sequencer, sample averaging,
// per-input hold timing, repeat interrupts and recalibration requests.
// Assumes touch flags and sample data come from front-end logic on SYS_CLK.
//
// Our own choice: the address-and-strobe port.
module tts_scheduler #(
  parameter int unsigned TICK_CYCLES = tts_pkg::TICK_CYCLES
) (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RESET,
  input  wire logic [7:0]               REG_ADDR,
  input  wire logic [7:0]               REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output logic [7:0]                    REG_RDATA,
  input  wire logic [7:0]               TOUCH_DET,
  input  wire logic [15:0]              SAMPLE_DATA,
  output tts_pkg::tts_sample_req_t      SAMPLE_REQ,
  output tts_pkg::tts_result_t          AVG_RESULT,
  output logic                          LOW_POWER,
  output logic [7:0]                    RECAL_REQ,
  output logic                          IRQ
);

  logic [7:0]  global_config_r;
  logic [7:0]  channel_enable_r;
  logic [7:0]  touch_timing_config_r;
  logic [7:0]  hold_detect_config_r;
  logic [7:0]  averaging_sampling_config_r;
  logic [7:0]  repeat_enable_r;
  logic [7:0]  event_status_r;
  logic [7:0]  event_mask_r;

  logic [15:0] tick_cnt_r;
  logic        tick;

  logic [23:0] hold_us_r [8];
  logic [23:0] rpt_us_r  [8];
  logic [7:0]  touch_prev_r;
  logic [7:0]  held_r;
  logic [7:0]  recal_done_r;

  logic [7:0]  onset;
  logic [7:0]  ev_release;
  logic [7:0]  ev_repeat;
  logic [7:0]  recal_fire;
  logic [7:0]  rpt_wrap;
  logic [7:0]  events;

  logic [3:0]  hold_limit_code;
  logic [3:0]  repeat_interval_code;
  logic [3:0]  press_code;
  logic [2:0]  sample_count_code;
  logic [1:0]  sample_period_code;
  logic [1:0]  cycle_code;
  logic        hold_limit_recal_enable;
  logic        release_int_disable;
  logic [23:0] hold_limit_us;
  logic [23:0] rpt_limit_us;
  logic [23:0] press_limit_us;
  logic [23:0] sample_us;
  logic [23:0] cycle_us;
  logic [7:0]  last_sample;

  tts_pkg::tts_seq_state_t state_r;
  logic [2:0]  ch_r;
  logic [7:0]  smp_cnt_r;
  logic [23:0] smp_us_r;
  logic [23:0] cyc_us_r;
  logic [22:0] acc_r;
  logic [22:0] acc_sum;
  logic        smp_end;
  logic        cycle_over;

  // Field extraction
  assign hold_limit_code      =
    touch_timing_config_r[tts_pkg::TT_HOLD_LSB +: 4];
  assign repeat_interval_code =
    touch_timing_config_r[tts_pkg::TT_REPEAT_LSB +: 4];
  assign press_code           =
    hold_detect_config_r[tts_pkg::HD_PRESS_LSB +: 4];
  assign sample_count_code    =
    averaging_sampling_config_r[tts_pkg::AS_COUNT_LSB +: 3];
  assign sample_period_code   =
    averaging_sampling_config_r[tts_pkg::AS_PERIOD_LSB +: 2];
  assign cycle_code           =
    averaging_sampling_config_r[tts_pkg::AS_CYCLE_LSB +: 2];
  assign hold_limit_recal_enable =
    global_config_r[tts_pkg::GC_RECAL_EN_BIT];
  assign release_int_disable  = global_config_r[tts_pkg::GC_REL_INT_DIS_BIT];

  // Decoded limits in microseconds
  assign hold_limit_us  = 24'(int'(tts_pkg::hold_limit_ms(hold_limit_code))
                          * tts_pkg::US_PER_MS);
  assign rpt_limit_us   = 24'((int'(repeat_interval_code) + 1)
                          * tts_pkg::REPEAT_STEP_MS
                          * tts_pkg::US_PER_MS);
  assign press_limit_us = 24'((int'(press_code) + 1)
                          * tts_pkg::PRESS_STEP_MS
                          * tts_pkg::US_PER_MS);
  assign sample_us      = 24'(tts_pkg::SAMPLE_BASE_US
                          << sample_period_code);
  assign cycle_us       = 24'((int'(cycle_code) + 1)
                          * tts_pkg::CYCLE_STEP_MS
                          * tts_pkg::US_PER_MS);
  assign last_sample    = 8'((1 << sample_count_code) - 1);

  // Microsecond timebase
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge SYS_CLK) begin
    if (RESET || tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  // Register writes
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      global_config_r             <= tts_pkg::RST_GLOBAL_CONFIG;
      channel_enable_r            <= tts_pkg::RST_CHANNEL_ENABLE;
      touch_timing_config_r       <= tts_pkg::RST_TOUCH_TIMING;
      hold_detect_config_r        <= tts_pkg::RST_HOLD_DETECT;
      averaging_sampling_config_r <= tts_pkg::RST_AVG_SAMPLING;
      repeat_enable_r             <= tts_pkg::RST_REPEAT_ENABLE;
      event_mask_r                <= tts_pkg::RST_EVENT_MASK;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        tts_pkg::OFF_GLOBAL_CONFIG: begin
          global_config_r <= REG_WDATA & 8'h09;
        end
        tts_pkg::OFF_CHANNEL_ENABLE: channel_enable_r <= REG_WDATA;
        tts_pkg::OFF_TOUCH_TIMING: touch_timing_config_r <= REG_WDATA;
        tts_pkg::OFF_HOLD_DETECT: begin
          hold_detect_config_r <= REG_WDATA & 8'h0f;
        end
        tts_pkg::OFF_AVG_SAMPLING: begin
          averaging_sampling_config_r <= REG_WDATA & 8'h7f;
        end
        tts_pkg::OFF_REPEAT_ENABLE: repeat_enable_r <= REG_WDATA;
        tts_pkg::OFF_EVENT_MASK: event_mask_r <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Read data stands for one cycle after the read strobe
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !REG_RD) begin
      REG_RDATA <= 8'h00;
    end else begin
      unique case (REG_ADDR)
        tts_pkg::OFF_GLOBAL_CONFIG:  REG_RDATA <= global_config_r;
        tts_pkg::OFF_CHANNEL_ENABLE: REG_RDATA <= channel_enable_r;
        tts_pkg::OFF_TOUCH_TIMING:   REG_RDATA <= touch_timing_config_r;
        tts_pkg::OFF_HOLD_DETECT:    REG_RDATA <= hold_detect_config_r;
        tts_pkg::OFF_AVG_SAMPLING:   REG_RDATA <= averaging_sampling_config_r;
        tts_pkg::OFF_REPEAT_ENABLE:  REG_RDATA <= repeat_enable_r;
        tts_pkg::OFF_EVENT_STATUS:   REG_RDATA <= event_status_r;
        tts_pkg::OFF_EVENT_MASK:     REG_RDATA <= event_mask_r;
        tts_pkg::OFF_HOLD_STATE:     REG_RDATA <= held_r;
        tts_pkg::OFF_SEQ_STATUS: begin
          REG_RDATA <= {2'b00, state_r == tts_pkg::TTS_SAMPLE,
                        state_r == tts_pkg::TTS_SLEEP, 1'b0, ch_r};
        end
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Per-input event decode
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      onset[i]    = TOUCH_DET[i] & ~touch_prev_r[i];
      rpt_wrap[i] = tick && (rpt_us_r[i] + 24'h000001 >= rpt_limit_us);
      // Press-and-hold ends silently; plain touches report release
      ev_release[i] = ~TOUCH_DET[i] & touch_prev_r[i] & ~release_int_disable
                      & ~(repeat_enable_r[i] & held_r[i]);
      ev_repeat[i]  = TOUCH_DET[i] & ~onset[i] & repeat_enable_r[i]
                      & held_r[i] & rpt_wrap[i];
      recal_fire[i] = hold_limit_recal_enable & TOUCH_DET[i] & ~onset[i]
                      & ~recal_done_r[i]
                      & (hold_us_r[i] > hold_limit_us);
    end
    events = onset | ev_release | ev_repeat;
  end

  // Per-input hold and repeat timers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      touch_prev_r <= 8'h00;
      held_r       <= 8'h00;
      recal_done_r <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        hold_us_r[i] <= 24'h000000;
        rpt_us_r[i]  <= 24'h000000;
      end
    end else begin
      touch_prev_r <= TOUCH_DET;
      for (int i = 0; i < 8; i++) begin
        if (!TOUCH_DET[i] || onset[i]) begin
          hold_us_r[i]    <= 24'h000000;
          rpt_us_r[i]     <= 24'h000000;
          held_r[i]       <= 1'b0;
          recal_done_r[i] <= 1'b0;
        end else begin
          if (tick && hold_us_r[i] != 24'hffffff) begin
            hold_us_r[i] <= hold_us_r[i] + 24'h000001;
          end
          if (rpt_wrap[i]) begin
            rpt_us_r[i] <= 24'h000000;
          end else if (tick) begin
            rpt_us_r[i] <= rpt_us_r[i] + 24'h000001;
          end
          // Only repeat inputs classify; otherwise remains a plain touch
          if (repeat_enable_r[i] && hold_us_r[i] > press_limit_us) begin
            held_r[i] <= 1'b1;
          end
          if (recal_fire[i]) begin
            recal_done_r[i] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      RECAL_REQ <= 8'h00;
    end else begin
      RECAL_REQ <= recal_fire;
    end
  end

  // Sticky event status, write one to clear, new events win
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      event_status_r <= 8'h00;
    end else if (REG_WR && REG_ADDR == tts_pkg::OFF_EVENT_STATUS) begin
      event_status_r <= (event_status_r & ~REG_WDATA) | events;
    end else begin
      event_status_r <= event_status_r | events;
    end
  end

  assign IRQ = |(event_status_r & event_mask_r);

  // Sensing-cycle sequencer
  assign smp_end    = tick && (smp_us_r + 24'h000001 >= sample_us);
  assign acc_sum    = acc_r + 23'(SAMPLE_DATA);
  assign cycle_over = (cyc_us_r >= cycle_us);
  assign LOW_POWER  = (state_r == tts_pkg::TTS_SLEEP);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cyc_us_r <= 24'h000000;
    end else if (state_r == tts_pkg::TTS_SLEEP && cycle_over) begin
      cyc_us_r <= 24'h000000;
    end else if (tick && cyc_us_r != 24'hffffff) begin
      cyc_us_r <= cyc_us_r + 24'h000001;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r    <= tts_pkg::TTS_SEEK;
      ch_r       <= 3'h0;
      smp_cnt_r  <= 8'h00;
      smp_us_r   <= 24'h000000;
      acc_r      <= 23'h000000;
      SAMPLE_REQ <= '0;
      AVG_RESULT <= '0;
    end else begin
      SAMPLE_REQ.start <= 1'b0;
      AVG_RESULT.valid <= 1'b0;
      unique case (state_r)
        tts_pkg::TTS_SLEEP: begin
          // Stretched cycles restart at once since the count is past
          if (cycle_over) begin
            ch_r    <= 3'h0;
            state_r <= tts_pkg::TTS_SEEK;
          end
        end
        tts_pkg::TTS_SEEK: begin
          if (channel_enable_r[ch_r]) begin
            smp_cnt_r          <= 8'h00;
            smp_us_r           <= 24'h000000;
            acc_r              <= 23'h000000;
            SAMPLE_REQ.start   <= 1'b1;
            SAMPLE_REQ.channel <= ch_r;
            state_r            <= tts_pkg::TTS_SAMPLE;
          end else if (ch_r == 3'h7) begin
            state_r <= tts_pkg::TTS_SLEEP;
          end else begin
            ch_r <= ch_r + 3'h1;
          end
        end
        tts_pkg::TTS_SAMPLE: begin
          if (smp_end) begin
            smp_us_r <= 24'h000000;
            // Lowering the count mid-measurement must not strand a channel
            if (smp_cnt_r >= last_sample) begin
              AVG_RESULT.valid   <= 1'b1;
              AVG_RESULT.channel <= ch_r;
              AVG_RESULT.value   <=
                16'(acc_sum >> sample_count_code);
              if (ch_r == 3'h7) begin
                state_r <= tts_pkg::TTS_SLEEP;
              end else begin
                ch_r    <= ch_r + 3'h1;
                state_r <= tts_pkg::TTS_SEEK;
              end
            end else begin
              acc_r              <= acc_sum;
              smp_cnt_r          <= smp_cnt_r + 8'h01;
              SAMPLE_REQ.start   <= 1'b1;
              SAMPLE_REQ.channel <= ch_r;
            end
          end else if (tick) begin
            smp_us_r <= smp_us_r + 24'h000001;
          end
        end
        default: state_r <= tts_pkg::TTS_SLEEP;
      endcase
    end
  end

endmodule

// >>> verification/tb_touch_timing_scheduler.sv
// Self-checking bench of the touch timing scheduler.
// Assumes one microsecond tick per clock (TICK_CYCLES of 1).
bind tts_scheduler tts_scheduler_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .TOUCH_DET(TOUCH_DET), .SAMPLE_DATA(SAMPLE_DATA),
  .SAMPLE_REQ(SAMPLE_REQ), .AVG_RESULT(AVG_RESULT), .LOW_POWER(LOW_POWER),
  .RECAL_REQ(RECAL_REQ), .IRQ(IRQ));
module tb_touch_timing_scheduler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T_SMP = tts_pkg::SAMPLE_BASE_US;
  localparam int T_CYC = tts_pkg::CYCLE_STEP_MS * tts_pkg::US_PER_MS;
  // Repeat interval for the repeat code 1 written in t_registers
  localparam int T_RPT = 2 * tts_pkg::REPEAT_STEP_MS * tts_pkg::US_PER_MS;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [7:0]               addr = 8'h00;
  logic [7:0]               wdata = 8'h00;
  logic                     wr_en = 1'b0;
  logic                     rd_en = 1'b0;
  logic [7:0]               rdata;
  logic [7:0]               touch = 8'h00;
  logic [15:0]              sdata;
  tts_pkg::tts_sample_req_t sreq;
  tts_pkg::tts_result_t     ares;
  logic                     lp;
  logic [7:0]               recal;
  logic                     irq;
  logic                     lp_q = 1'b0;
  int                       mismatches = 0;
  int                       tests_run = 0;
  int                       cyc = 0;
  int                       fall_prev = 0;
  int                       fall_last = 0;
  tts_pkg::tts_result_t     res_q[$];
  tts_scheduler #(.TICK_CYCLES(1)) uut (.SYS_CLK(clk), .RESET(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_en), .REG_RD(rd_en),
    .REG_RDATA(rdata), .TOUCH_DET(touch), .SAMPLE_DATA(sdata),
    .SAMPLE_REQ(sreq), .AVG_RESULT(ares), .LOW_POWER(lp),
    .RECAL_REQ(recal), .IRQ(irq));
  tts_front_model fe (.SYS_CLK(clk), .RESET(rst), .SAMPLE_REQ(sreq),
    .SAMPLE_DATA(sdata));
  always #2 clk = ~clk;
  // Cycle count, cycle-start times and collected results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lp_q <= lp;
    if (lp_q === 1'b1 && lp === 1'b0) begin
      fall_prev <= fall_last;
      fall_last <= cyc;
    end
    if (ares.valid === 1'b1) res_q.push_back(ares);
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a,
                    input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(what, {24'h0, exp}, {24'h0, rdata});
  endtask
  task automatic await(input string what, input logic lp_v, input int n);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (i < n && ((what == "start") ? sreq.start !== 1'b1
                                           : lp !== lp_v));
    if (i >= n) begin
      chk({what, " timeout"}, 1, 0);
      report_and_stop();
    end
  endtask
  task automatic touch_set(input logic [7:0] v);
    @(posedge clk);
    touch <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_registers();
    rd("touch timing reset", 8'h22, 8'ha4);
    rd("hold detect reset", 8'h23, 8'h07);
    rd("avg sampling reset", 8'h24, 8'h39);
    rd("unmapped", 8'h25, 8'h00);
    wr(8'h23, 8'hf0);
    rd("hold detect reserved", 8'h23, 8'h00);
    wr(8'h22, 8'h01);
    wr(8'h21, 8'h05);
    wr(8'h24, 8'h90);
    rd("avg sampling write", 8'h24, 8'h10);
  endtask
  task automatic t_sequence();
    int t_prev;
    logic [2:0] ch_exp [4] = '{3'h0, 3'h0, 3'h2, 3'h2};
    // Leaving ch0 and skipping disabled ch1 cost two seek cycles
    int gap_exp [4] = '{0, T_SMP, T_SMP + 2, T_SMP};
    t_prev = 0;
    await("low", 1'b1, 40000);
    await("high", 1'b0, 40000);
    res_q.delete();
    for (int k = 0; k < 4; k++) begin
      await("start", 1'b0, 400);
      chk("sample channel", ch_exp[k], sreq.channel);
      if (k > 0) chk("sample gap", gap_exp[k], cyc - t_prev);
      t_prev = cyc;
    end
    await("low", 1'b1, 400);
    chk("result count", 2, res_q.size());
    if (res_q.size() == 2) begin
      chk("result ch0", {1'b1, 3'h0, 16'h0020}, res_q[0]);
      chk("result ch2", {1'b1, 3'h2, 16'h2020}, res_q[1]);
    end
  endtask
  task automatic t_press_hold();
    wr(8'h30, 8'hff);
    touch_set(8'h02);
    chk("irq on touch", 1, irq);
    rd("touch status", 8'h30, 8'h02);
    wr(8'h30, 8'h02);
    repeat (T_CYC - 100) @(posedge clk);
    rd("held early", 8'h32, 8'h00);
    repeat (200) @(posedge clk);
    rd("held late", 8'h32, 8'h02);
    rd("no early repeat", 8'h30, 8'h00);
    repeat (T_RPT - T_CYC - 130) @(posedge clk);
    rd("repeat not yet due", 8'h30, 8'h00);
    repeat (20) @(posedge clk);
    rd("repeat status", 8'h30, 8'h02);
    chk("irq on repeat", 1, irq);
    wr(8'h30, 8'h02);
    touch_set(8'h00);
    rd("no release event", 8'h30, 8'h00);
    rd("held cleared", 8'h32, 8'h00);
  endtask
  task automatic t_plain_touch();
    wr(8'h28, 8'h00);
    wr(8'h31, 8'h00);
    touch_set(8'h08);
    chk("masked irq", 0, irq);
    rd("plain touch status", 8'h30, 8'h08);
    wr(8'h31, 8'hff);
    #1;
    chk("unmasked irq", 1, irq);
    wr(8'h30, 8'h08);
    #1;
    chk("irq after clear", 0, irq);
    touch_set(8'h00);
    rd("release status", 8'h30, 8'h08);
    rd("plain held", 8'h32, 8'h00);
    wr(8'h30, 8'hff);
    wr(8'h20, 8'h01);
    touch_set(8'h08);
    wr(8'h30, 8'h08);
    touch_set(8'h00);
    rd("release suppressed", 8'h30, 8'h00);
  endtask
  task automatic t_cycle_period();
    int d;
    if (fall_prev == 0) begin
      await("low", 1'b1, 40000);
      await("high", 1'b0, 40000);
      repeat (2) @(posedge clk);
    end
    d = fall_last - fall_prev;
    chk("cycle length", 1, d >= T_CYC && d <= T_CYC + 2);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_registers();
    // Sequencer checks use no bus, so they share the long hold wait
    fork
      t_sequence();
      t_press_hold();
    join
    t_plain_touch();
    t_cycle_period();
    report_and_stop();
  end
endmodule

// >>> verification/tts_front_model.sv
// Behavioural measurement front end answering each sample request.
// Assumes SAMPLE_REQ comes from the scheduler on the same clock.
module tts_front_model (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RESET,
  input  wire tts_pkg::tts_sample_req_t SAMPLE_REQ,
  output logic [15:0]                   SAMPLE_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  last_ch_r;
  logic [15:0] step_r;
  // Sample k of a run on channel c reads 1000h*c + 10h + 20h*k
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      last_ch_r   <= 3'h0;
      step_r      <= 16'h0000;
      SAMPLE_DATA <= 16'h5a5a;
    end else if (SAMPLE_REQ.start) begin
      last_ch_r <= SAMPLE_REQ.channel;
      if (SAMPLE_REQ.channel != last_ch_r) begin
        SAMPLE_DATA <= {1'b0, SAMPLE_REQ.channel, 12'h010};
        step_r      <= 16'h0020;
      end else begin
        SAMPLE_DATA <= {1'b0, SAMPLE_REQ.channel, 12'h010} + step_r;
        step_r      <= step_r + 16'h0020;
      end
    end
  end
endmodule

// >>> verification/tts_scheduler_monitor.sv
// Port-level assertions of the touch timing scheduler.
// Bound into tts_scheduler; one clock, synchronous active-high reset.
module tts_scheduler_monitor #(
  parameter int unsigned TICK_CYCLES = 1
) (
  input wire logic                     SYS_CLK,
  input wire logic                     RESET,
  input wire logic [7:0]               REG_ADDR,
  input wire logic [7:0]               REG_WDATA,
  input wire logic                     REG_WR,
  input wire logic                     REG_RD,
  input wire logic [7:0]               REG_RDATA,
  input wire logic [7:0]               TOUCH_DET,
  input wire logic [15:0]              SAMPLE_DATA,
  input wire tts_pkg::tts_sample_req_t SAMPLE_REQ,
  input wire tts_pkg::tts_result_t     AVG_RESULT,
  input wire logic                     LOW_POWER,
  input wire logic [7:0]               RECAL_REQ,
  input wire logic                     IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  localparam int unsigned MIN_GAP = 320 * TICK_CYCLES;
  logic        recal_en_r;
  logic [7:0]  mask_r;
  logic [19:0] gap_r;
  // Shadows of the recalibration enable and the event mask
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      recal_en_r <= 1'b0;
      mask_r     <= 8'hff;
    end else if (REG_WR && REG_ADDR == 8'h20) begin
      recal_en_r <= REG_WDATA[3];
    end else if (REG_WR && REG_ADDR == 8'h31) begin
      mask_r <= REG_WDATA;
    end
  end
  // Clocks since the last sample start, saturating
  always_ff @(posedge SYS_CLK) begin
    if (RESET) gap_r <= 20'hfffff;
    else if (SAMPLE_REQ.start) gap_r <= 20'h00001;
    else if (gap_r != 20'hfffff) gap_r <= gap_r + 20'h00001;
  end
  property p_chan_hold;
    !SAMPLE_REQ.start |-> $stable(SAMPLE_REQ.channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold)
    else $error("sample channel moved without a start");
  property p_result_hold;
    !AVG_RESULT.valid |-> $stable({AVG_RESULT.channel, AVG_RESULT.value});
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without valid");
  property p_result_pulse;
    AVG_RESULT.valid |=> !AVG_RESULT.valid;
  endproperty
  a_result_pulse: assert property (p_result_pulse)
    else $error("result valid longer than one cycle");
  property p_quiet_low_power;
    LOW_POWER |-> !SAMPLE_REQ.start;
  endproperty
  a_quiet_low_power: assert property (p_quiet_low_power)
    else $error("sample started in low power");
  property p_cycle_opens;
    $fell(LOW_POWER) |-> ##[0:9] SAMPLE_REQ.start;
  endproperty
  a_cycle_opens: assert property (p_cycle_opens)
    else $error("cycle opened without sampling");
  property p_sample_gap;
    SAMPLE_REQ.start |-> gap_r >= MIN_GAP;
  endproperty
  a_sample_gap: assert property (p_sample_gap)
    else $error("sample shorter than the minimum period");
  property p_touch_irq;
    (TOUCH_DET & ~$past(TOUCH_DET) & mask_r) != 8'h00 |=> IRQ;
  endproperty
  a_touch_irq: assert property (p_touch_irq)
    else $error("no interrupt after touch onset");
  property p_recal_gated;
    RECAL_REQ != 8'h00 |-> recal_en_r;
  endproperty
  a_recal_gated: assert property (p_recal_gated)
    else $error("recalibration while disabled");
  property p_recal_pulse;
    RECAL_REQ != 8'h00 |=> RECAL_REQ == 8'h00;
  endproperty
  a_recal_pulse: assert property (p_recal_pulse)
    else $error("recalibration request not a pulse");
endmodule
